// *** sim/hcs_channel1_status_test.sv ***
`timescale 1ns/1ps
module hcs_channel1_status_test import hcs_pkg::*;;
    logic sys_clk = 1'b0;     // 50 ns clock
    logic reset_n = 1'b0;     // async reset, active low
    logic [2:0] op = 3'h0;    // host model request
    hcs_host_ev_s hev;        // host strobes from the model
    hcs_slave_ev_s sev = '0;  // slave strobes, driven here
    logic [7:0] st;           // live status view
    logic [7:0] hrd;          // host read snapshot
    logic irq;                // input-full interrupt request
    int n_errors = 0;         // mismatches counted
    int num_checks = 0;       // comparisons made
    always #25 sys_clk = ~sys_clk;
    hcs_host hcs_host_i (.op(op), .ev(hev));
    hcs_channel1_status hcs_channel1_status_i (.sys_clk(sys_clk),
        .reset_n(reset_n), .host_ev(hev), .slave_ev(sev),
        .channel1_status_reg(st), .host_rdata(hrd), .input_full_irq(irq));
    // one cycle of host op and slave strobes together
    task go(input logic [2:0] o, input logic [10:0] s);
        @(posedge sys_clk);
        #1 op = o;
        sev = s;
        @(posedge sys_clk);
        #1 op = 3'h0;
        sev = '0;
    endtask
    task cmp(input logic [8:0] got, input logic [8:0] e);
        num_checks++;
        if (got !== e) begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, e);
        end
    endtask
    task conclude;
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        cmp({irq, st}, 9'h000);
        go(3'h5, 11'h000);
        cmp({irq, st}, 9'h000);
        go(3'h2, 11'h000);
        cmp({irq, st}, 9'h10A);
        go(3'h1, 11'h002);
        cmp({irq, st}, 9'h102);
        go(3'h0, 11'h002);
        cmp({irq, st}, 9'h000);
        go(3'h0, 11'h7FC);
        cmp({irq, st}, 9'h0F4);
        go(3'h5, 11'h000);
        cmp({irq, st}, 9'h0F4);
        go(3'h0, 11'h001);
        cmp({irq, st}, 9'h0F5);
        go(3'h4, 11'h000);
        cmp({1'b0, hrd}, 9'h0F5);
        go(3'h3, 11'h000);
        cmp({irq, st}, 9'h0F4);
        go(3'h0, 11'h001);
        go(3'h0, 11'h7D0);
        cmp({irq, st}, 9'h0F4);
        go(3'h0, 11'h401);
        cmp({irq, st}, 9'h001);
        go(3'h2, 11'h001);
        cmp({irq, st}, 9'h10B);
        // reset in mid-run clears every field and the snapshot
        @(posedge sys_clk);
        #1 reset_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 cmp({irq, st}, 9'h000);
        cmp({1'b0, hrd}, 9'h000);
        reset_n = 1'b1;
        go(3'h4, 11'h000);
        cmp({1'b0, hrd}, 9'h000);
        conclude;
    end
    // watchdog, far beyond the few dozen cycles above
    initial begin
        #100000;
        n_errors++;
        conclude;
    end
endmodule

// *** sim/hcs_chk.sv ***
`timescale 1ns/1ps
// checker sees only the top ports
module hcs_chk import hcs_pkg::*; (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire hcs_host_ev_s host_ev,
    input wire hcs_slave_ev_s slave_ev,
    input wire logic [7:0] channel1_status_reg,
    input wire logic [7:0] host_rdata,
    input wire logic input_full_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    a_irq_mirror: assert property (
        input_full_irq == channel1_status_reg[1])
        else $error("irq differs from input flag");
    a_in_set: assert property (
        host_ev.in_data_wr |=> channel1_status_reg[1])
        else $error("input flag not set");
    a_cd_cap: assert property (
        host_ev.in_data_wr |=>
        channel1_status_reg[3] == $past(host_ev.in_addr_bit2))
        else $error("cmd indicator wrong");
    a_in_clr: assert property (
        slave_ev.in_data_rd && !host_ev.in_data_wr
        |=> !channel1_status_reg[1])
        else $error("input flag kept");
    a_out_set: assert property (
        slave_ev.out_data_wr |=> channel1_status_reg[0])
        else $error("output flag not set");
    a_out_clr: assert property (
        host_ev.out_data_rd && !slave_ev.out_data_wr
        |=> !channel1_status_reg[0])
        else $error("output flag kept");
    a_user_wr: assert property (
        slave_ev.status_wr |=>
        (channel1_status_reg & 8'hF4) == ($past(slave_ev.wdata) & 8'hF4))
        else $error("user bits wrong");
    a_rd_snap: assert property (
        host_ev.status_rd |=>
        host_rdata == $past(channel1_status_reg))
        else $error("host read data wrong");
    a_host_wr_ign: assert property (
        host_ev.status_wr && !host_ev.in_data_wr && !host_ev.out_data_rd
        && slave_ev == '0 |=> $stable(channel1_status_reg))
        else $error("host status write changed register");
endmodule
bind hcs_channel1_status hcs_chk hcs_chk_i (.*);

// *** sim/hcs_host.sv ***
`timescale 1ns/1ps
// host model: op 1 data wr, 2 cmd wr, 3 odr rd, 4 status rd, 5 status wr
module hcs_host import hcs_pkg::*; (
    input wire logic [2:0] op,
    output hcs_host_ev_s ev
);
    // address bit 2 high only for command writes
    assign ev = '{op == 3'h1 || op == 3'h2,
                  op == 3'h2,
                  op == 3'h3,
                  op == 3'h4,
                  op == 3'h5};
endmodule

// *** verilog/hcs_channel1_status.sv ***
`timescale 1ns/1ps
`include "hcs_params.svh"

module hcs_channel1_status
    import hcs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire hcs_host_ev_s host_ev,
    input wire hcs_slave_ev_s slave_ev,
    output logic [7:0] channel1_status_reg,
    output logic [7:0] host_rdata,
    output logic input_full_irq
);

    // all strobes come from logic on sys_clk, so no synchronisers;
    // a strobe is taken at the rising edge where it is high and the
    // new status is visible in the following cycle

    // stored user bits, only positions of the user mask are used
    logic [7:0] user_bits_r;
    // next value of the user bits
    logic [7:0] user_bits_nxt;
    // command/data indicator: 0 data, 1 command
    logic cmd_data_indicator_r;
    // next value of the indicator
    logic cmd_data_indicator_nxt;
    // input-full flag: host wrote, slave not yet read
    logic input_full_flag_r;
    // next value of the input-full flag
    logic input_full_flag_nxt;
    // output-full flag: slave wrote, host not yet read
    logic output_full_flag_r;
    // next value of the output-full flag
    logic output_full_flag_nxt;
    // status snapshot returned to the host
    logic [7:0] host_rdata_r;
    // next value of the snapshot
    logic [7:0] host_rdata_nxt;
    // slave wrote 0 to the output-full position
    logic out_full_slave_clr;
    // any clearing event for the output-full flag
    logic out_full_clr;

    // set/clear update shared by both handshake flags;
    // the set term is tested first so no transfer is ever lost
    function automatic logic flag_next(
        input logic cur,  // present flag value
        input logic set,  // hardware set event
        input logic clr   // any clearing event
    );
        logic res;        // value being built
        res = cur;
        if (set) begin
            // set wins over a clear in the same cycle
            res = 1'b1;
        end else if (clr) begin
            res = 1'b0;
        end
        return res;
    endfunction

    // merge of the stored fields into one register image
    function automatic logic [7:0] merge_status(
        input logic [7:0] user,  // user bits, masked
        input logic cd,          // command/data indicator
        input logic in_full,     // input-full flag
        input logic out_full     // output-full flag
    );
        logic [7:0] img;         // image being built
        img = user & `HCS_USER_MASK;
        img[`HCS_BIT_CMD_DATA] = cd;
        img[`HCS_BIT_IN_FULL] = in_full;
        img[`HCS_BIT_OUT_FULL] = out_full;
        return img;
    endfunction

    // user bits next value: only a slave status write touches them;
    // a host write aimed at the status register is never looked at,
    // which keeps the host side strictly read-only
    always_comb begin
        user_bits_nxt = user_bits_r;
        if (slave_ev.status_wr) begin
            // flag positions masked off so they stay zero here
            user_bits_nxt = slave_ev.wdata & `HCS_USER_MASK;
        end
        // host_ev.status_wr has no path here
    end

    // user bits register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            user_bits_r <= `HCS_STATUS_RESET;
        end else begin
            user_bits_r <= user_bits_nxt;
        end
    end

    // indicator next value: follows every host input write,
    // even one that falls together with other events
    always_comb begin
        cmd_data_indicator_nxt = cmd_data_indicator_r;
        if (host_ev.in_data_wr) begin
            // address bit 2: 0 data, 1 command
            cmd_data_indicator_nxt = host_ev.in_addr_bit2;
        end
    end

    // indicator register; neither side writes it directly
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_data_indicator_r <= 1'b0;
        end else begin
            cmd_data_indicator_r <= cmd_data_indicator_nxt;
        end
    end

    // input-full next value; only the normal set and clear terms,
    // the fast gate variant is left to a wrapper that needs it
    always_comb begin
        // host write sets, slave read of the input data clears
        input_full_flag_nxt = flag_next(input_full_flag_r,
                                        host_ev.in_data_wr,
                                        slave_ev.in_data_rd);
        // no alternative conditions built in
    end

    // input-full flag register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            input_full_flag_r <= 1'b0;
        end else begin
            input_full_flag_r <= input_full_flag_nxt;
        end
    end

    // output-full clear terms: host read of output data, or a slave
    // status write with 0 in the flag position; writing 1 is ignored
    always_comb begin
        out_full_slave_clr = slave_ev.status_wr &&
                             !slave_ev.wdata[`HCS_BIT_OUT_FULL];
        out_full_clr = host_ev.out_data_rd ||
                       out_full_slave_clr;
    end

    // output-full next value
    always_comb begin
        // slave data write sets, either clear term resets
        output_full_flag_nxt = flag_next(output_full_flag_r,
                                         slave_ev.out_data_wr,
                                         out_full_clr);
    end

    // output-full flag register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            output_full_flag_r <= 1'b0;
        end else begin
            output_full_flag_r <= output_full_flag_nxt;
        end
    end

    // assembled register view, slave read side
    always_comb begin
        channel1_status_reg = merge_status(user_bits_r,
                                           cmd_data_indicator_r,
                                           input_full_flag_r,
                                           output_full_flag_r);
    end

    // snapshot next value: taken on a host status read strobe;
    // the host sees the image as it stood at that edge
    always_comb begin
        host_rdata_nxt = host_rdata_r;
        if (host_ev.status_rd) begin
            host_rdata_nxt = channel1_status_reg;
        end
    end

    // host read data register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            host_rdata_r <= `HCS_STATUS_RESET;
        end else begin
            host_rdata_r <= host_rdata_nxt;
        end
    end

    // read data straight from its flip-flops
    assign host_rdata = host_rdata_r;

    // interrupt request is simply the flag level, no extra delay
    assign input_full_irq = input_full_flag_r;

endmodule

// *** verilog/hcs_params.svh ***
`ifndef HCS_PARAMS_SVH
`define HCS_PARAMS_SVH

// status register field positions
`define HCS_BIT_USER_HI 7
`define HCS_BIT_USER_LO 4
`define HCS_BIT_CMD_DATA 3
`define HCS_BIT_USER_2 2
`define HCS_BIT_IN_FULL 1
`define HCS_BIT_OUT_FULL 0

// reset value of the whole status register
`define HCS_STATUS_RESET 8'h00

// slave-writable bits: user bits only, flags handled separately
`define HCS_USER_MASK 8'hF4

// host i/o address bit that selects command versus data
`define HCS_ADDR_CMD_BIT 2

`endif

// *** verilog/hcs_pkg.sv ***
package hcs_pkg;

    // host-side events, one-cycle strobes from the lpc cycle decoder
    typedef struct packed {
        logic in_data_wr;    // host i/o write to host_input_data_reg
        logic in_addr_bit2;  // i/o address bit 2 of that write
        logic out_data_rd;   // host i/o read of host_output_data_reg
        logic status_rd;     // host i/o read of the status register
        logic status_wr;     // host i/o write aimed at the status register
    } hcs_host_ev_s;

    // slave cpu events, one-cycle strobes from the internal bus
    typedef struct packed {
        logic status_wr;     // slave write of the status register
        logic [7:0] wdata;   // data of that write
        logic in_data_rd;    // slave read of host_input_data_reg
        logic out_data_wr;   // slave write of host_output_data_reg
    } hcs_slave_ev_s;

endpackage
